/* rtl/ssc_top.sv */
// System state controller: clocks, reset sequencing, cause and flag regs
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/10ps
`include "ssc_params.svh"
module ssc_top #(
  parameter logic [12:0] PIN_POR_CYC = `SSC_PIN_POR_CYC
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic [17:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic power_up_pulse_in,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe_out,
  input wire logic watchdog_timeout_in,
  input wire logic illegal_opcode_in,
  input wire logic illegal_addr_in,
  input wire logic usb_reset_in,
  input wire logic stop_req_in,
  input wire logic wait_req_in,
  input wire logic wake_in,
  input wire logic monitor_mode_in,
  input wire logic [23:0] irq_src_in,
  output logic internal_reset_signal_out,
  output logic [15:0] reset_vector_out,
  output logic irq_pending_out,
  output logic irq_out,
  output logic half_osc_clock_out,
  output logic cpu_clk_out,
  output logic periph_clk_out
);
  ssc_pkg::ssc_top_st_t s_q;
  ssc_pkg::ssc_top_st_t s_d;

  function automatic logic [15:0] reg_idx(input logic [17:0] a);
    return a[17:2];
  endfunction : reg_idx

  function automatic logic [7:0] rd_mux(input logic [15:0] idx,
                                        input ssc_pkg::ssc_top_st_t s);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      `SSC_IDX_FLAGS_LO: v = {s.flags[5:0], 2'h0};
      `SSC_IDX_FLAGS_MID: v = {3'h0, s.flags[10:6]};
      `SSC_IDX_FLAGS_HI: v = 8'h00;
      `SSC_IDX_CAUSE: v = {2'h0, s.cause};
      `SSC_IDX_STATUS: v = {5'h00, s.sts};
      `SSC_IDX_MASK: v = {5'h00, s.msk};
      `SSC_IDX_CTRL: v = {7'h00, s.ssr};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : rd_mux

  always_comb begin
    logic req;
    logic wr;
    logic [15:0] idx;
    logic [2:0] clr;
    logic [2:0] ev;
    logic [12:0] lim;
    logic [12:0] thr;
    logic int_rst;
    logic [5:0] int_cause;
    logic live;
    req = avs_read_in | avs_write_in;
    wr = avs_write_in & ~s_q.wreq & avs_byteenable_in[0];
    idx = reg_idx(avs_address_in);
    clr = 3'h0;
    ev = 3'h0;
    lim = s_q.ssr ? `SSC_STOP_SHORT : `SSC_STOP_LONG;
    thr = s_q.por ? PIN_POR_CYC : `SSC_PIN_CYC;
    int_cause = '0;
    int_cause[`SSC_CAUSE_WDOG] = watchdog_timeout_in;
    int_cause[`SSC_CAUSE_ILOP] = illegal_opcode_in;
    int_cause[`SSC_CAUSE_ILAD] = illegal_addr_in;
    int_cause[`SSC_CAUSE_USB] = usb_reset_in;
    int_rst = |int_cause;
    live = (s_q.st == ssc_pkg::ST_RUN) || (s_q.st == ssc_pkg::ST_WAIT) ||
           (s_q.st == ssc_pkg::ST_STOP) || (s_q.st == ssc_pkg::ST_REC);
    s_d = s_q;
    // One wait state on every access; unmapped reads give zero
    s_d.wreq = ~(req & s_q.wreq);
    if (req & s_q.wreq) begin
      s_d.rdata = rd_mux(idx, s_q);
    end
    if (wr) begin
      unique case (idx)
        `SSC_IDX_STATUS: clr = avs_writedata_in[2:0];
        `SSC_IDX_MASK: s_d.msk = avs_writedata_in[2:0];
        `SSC_IDX_CTRL: s_d.ssr = avs_writedata_in[`SSC_CTRL_SSR];
        default: clr = 3'h0;
      endcase
    end
    s_d.flags = irq_src_in[10:0];
    s_d.pend = |irq_src_in;
    ev[`SSC_EV_IRQ] = s_d.pend & ~s_q.pend;
    s_d.sys_cnt = s_q.sys_cnt + 13'h0001;
    // Pin low counter, saturating
    if (!rst_pin_in) begin
      if (s_q.pin_cnt != 13'h1fff) begin
        s_d.pin_cnt = s_q.pin_cnt + 13'h0001;
      end
      if (s_q.pin_cnt == thr - 13'h0001) begin
        s_d.cause[`SSC_CAUSE_PIN] = 1'b1;
      end
    end else begin
      s_d.pin_cnt = 13'h0000;
    end
    unique case (s_q.st)
      ssc_pkg::ST_POR: begin
        if (s_q.sys_cnt == `SSC_POR_CYC - 13'h0001) begin
          s_d.st = ssc_pkg::ST_DRV;
          s_d.ph = 6'h00;
        end
      end
      ssc_pkg::ST_DRV: begin
        s_d.ph = s_q.ph + 6'h01;
        if (s_q.ph == `SSC_DRIVE_CYC - 6'h01) begin
          s_d.st = ssc_pkg::ST_HLD;
        end
      end
      ssc_pkg::ST_HLD: begin
        s_d.ph = s_q.ph + 6'h01;
        if (s_q.ph == `SSC_DRIVE_CYC + `SSC_HOLD_CYC - 6'h01) begin
          s_d.st = ssc_pkg::ST_RUN;
          s_d.por = 1'b0;
        end
      end
      ssc_pkg::ST_RUN: begin
        if (stop_req_in) begin
          s_d.st = ssc_pkg::ST_STOP;
          s_d.sys_cnt = 13'h0000;
        end else if (wait_req_in) begin
          s_d.st = ssc_pkg::ST_WAIT;
        end
      end
      ssc_pkg::ST_EXT: begin
        // Pin release: hold internal reset for the same tail as internal
        if (rst_pin_in) begin
          s_d.st = ssc_pkg::ST_HLD;
          s_d.ph = `SSC_DRIVE_CYC;
        end
      end
      ssc_pkg::ST_STOP: begin
        s_d.sys_cnt = 13'h0000;
        if (wake_in) begin
          s_d.st = ssc_pkg::ST_REC;
        end
      end
      ssc_pkg::ST_REC: begin
        if (s_q.sys_cnt == lim - 13'h0001) begin
          s_d.st = ssc_pkg::ST_RUN;
          ev[`SSC_EV_STOP] = 1'b1;
        end
      end
      ssc_pkg::ST_WAIT: begin
        if (wake_in) begin
          s_d.st = ssc_pkg::ST_RUN;
          ev[`SSC_EV_WAIT] = 1'b1;
        end
      end
      default: begin
        s_d.st = ssc_pkg::ST_POR;
        s_d.sys_cnt = 13'h0000;
      end
    endcase
    // Set wins over a clear in the same cycle
    s_d.sts = (s_q.sts & ~clr) | ev;
    // Pin low from outside, not our own drive: halt everything
    if (!rst_pin_in && !s_q.pin_oe && s_q.st != ssc_pkg::ST_EXT) begin
      s_d.st = ssc_pkg::ST_EXT;
      s_d.sts = 3'h0;
      s_d.msk = `SSC_MASK_RST;
      s_d.ssr = `SSC_CTRL_RST;
    end
    if (int_rst && live) begin
      s_d.st = ssc_pkg::ST_DRV;
      s_d.ph = 6'h00;
      s_d.sys_cnt = 13'h0000;
      s_d.cause = int_cause;
      s_d.sts = 3'h0;
      s_d.msk = `SSC_MASK_RST;
      s_d.ssr = `SSC_CTRL_RST;
    end
    if (power_up_pulse_in) begin
      s_d.st = ssc_pkg::ST_POR;
      s_d.sys_cnt = 13'h0000;
      s_d.por = 1'b1;
      s_d.cause = 6'h00;
      s_d.cause[`SSC_CAUSE_POR] = 1'b1;
      s_d.sts = 3'h0;
      s_d.msk = `SSC_MASK_RST;
      s_d.ssr = `SSC_CTRL_RST;
    end
    s_d.internal_reset_signal = !((s_d.st == ssc_pkg::ST_RUN) ||
                 (s_d.st == ssc_pkg::ST_WAIT) ||
                 (s_d.st == ssc_pkg::ST_STOP) ||
                 (s_d.st == ssc_pkg::ST_REC));
    s_d.pin_oe = (s_d.st == ssc_pkg::ST_POR) ||
                 (s_d.st == ssc_pkg::ST_DRV);
    s_d.cpu_run = (s_d.st == ssc_pkg::ST_RUN);
    s_d.per_run = (s_d.st == ssc_pkg::ST_RUN) ||
                  (s_d.st == ssc_pkg::ST_WAIT);
    if (s_d.internal_reset_signal) begin
      s_d.vec = monitor_mode_in ? `SSC_VEC_MON : `SSC_VEC_USER;
    end
    s_d.irq = |(s_d.sts & s_d.msk);
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= '0;
      s_q.st <= ssc_pkg::ST_POR;
      s_q.por <= 1'b1;
      s_q.cause <= 6'h01;
      s_q.msk <= `SSC_MASK_RST;
      s_q.ssr <= `SSC_CTRL_RST;
      s_q.wreq <= 1'b1;
      s_q.internal_reset_signal <= 1'b1;
      s_q.pin_oe <= 1'b1;
      s_q.vec <= `SSC_VEC_USER;
    end else begin
      s_q <= s_d;
    end
  end

  ssc_bus_clk u_clk (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .cpu_run_in(s_q.cpu_run),
    .periph_run_in(s_q.per_run),
    .half_osc_clock_out(half_osc_clock_out),
    .cpu_clk_out(cpu_clk_out),
    .periph_clk_out(periph_clk_out)
  );

  assign avs_readdata_out = {24'h000000, s_q.rdata};
  assign avs_waitrequest_out = s_q.wreq;
  // Pin is only ever pulled low; the enable carries the drive
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe_out = s_q.pin_oe;
  assign internal_reset_signal_out = s_q.internal_reset_signal;
  assign reset_vector_out = s_q.vec;
  assign irq_pending_out = s_q.pend;
  assign irq_out = s_q.irq;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  a_por_pin_low: assert property (
    s_q.st == ssc_pkg::ST_POR |-> s_q.pin_oe && s_q.internal_reset_signal)
    else $error("pin not driven low during power-on wait");
  a_por_timeout: assert property (
    s_q.st == ssc_pkg::ST_POR && s_q.sys_cnt == 13'h0fff &&
    !power_up_pulse_in |=> s_q.st == ssc_pkg::ST_DRV)
    else $error("power-on wait not 4096 cycles");
  a_clk_held_reset: assert property (
    s_q.internal_reset_signal |-> !s_q.cpu_run && !s_q.per_run)
    else $error("clocks running under internal reset");
  a_drive_then_hold: assert property (
    s_q.st == ssc_pkg::ST_DRV && s_q.ph == 6'h1f && !power_up_pulse_in
    |=> s_q.st == ssc_pkg::ST_HLD && !s_q.pin_oe && s_q.internal_reset_signal)
    else $error("pin drive not 32 cycles");
  a_hold_release: assert property (
    s_q.st == ssc_pkg::ST_HLD && s_q.ph == 6'h3f && !power_up_pulse_in &&
    rst_pin_in && !(|{watchdog_timeout_in, illegal_opcode_in,
    illegal_addr_in, usb_reset_in}) |=> !s_q.internal_reset_signal ##1 s_q.cpu_run)
    else $error("internal reset tail not 32 cycles");
  a_short_recovery: assert property (
    s_q.st == ssc_pkg::ST_REC && s_q.ssr && s_q.sys_cnt == 13'h001f &&
    rst_pin_in && !power_up_pulse_in && !watchdog_timeout_in &&
    !illegal_opcode_in && !illegal_addr_in && !usb_reset_in
    |=> s_q.st == ssc_pkg::ST_RUN)
    else $error("short stop recovery not 32 cycles");
  a_long_recovery: assert property (
    s_q.st == ssc_pkg::ST_REC && !s_q.ssr && s_q.sys_cnt < 13'h0fff
    |=> s_q.st != ssc_pkg::ST_RUN)
    else $error("long stop recovery ended early");
  a_stop_clk_off: assert property (
    s_q.st == ssc_pkg::ST_REC |-> !s_q.cpu_run && !s_q.per_run)
    else $error("clocks on before stop delay expired");
  a_wait_clocks: assert property (
    s_q.st == ssc_pkg::ST_WAIT |-> !s_q.cpu_run && s_q.per_run)
    else $error("wrong clocks in wait mode");
  a_int_reset_cnt: assert property (
    s_q.st == ssc_pkg::ST_RUN && watchdog_timeout_in && !power_up_pulse_in
    |=> s_q.st == ssc_pkg::ST_DRV && s_q.sys_cnt == 13'h0000 &&
    s_q.cause[`SSC_CAUSE_WDOG] && s_q.internal_reset_signal)
    else $error("watchdog reset did not restart sequence");
  a_flags_follow: assert property (
    ##1 s_q.flags == $past(irq_src_in[10:0]))
    else $error("flag does not follow its source");
  a_vector_sel: assert property (
    s_q.internal_reset_signal && $past(s_q.internal_reset_signal) |-> s_q.vec ==
    ($past(monitor_mode_in) ? `SSC_VEC_MON : `SSC_VEC_USER))
    else $error("wrong reset vector");
  a_irq_level: assert property (
    s_q.irq == |(s_q.sts & s_q.msk))
    else $error("interrupt output not status and mask");
  a_bus_one_wait: assert property (
    !s_q.wreq |=> s_q.wreq)
    else $error("waitrequest low for more than one cycle");

  c_por_done: cover property (
    s_q.st == ssc_pkg::ST_HLD ##1 s_q.st == ssc_pkg::ST_RUN);
  c_stop_short: cover property (
    s_q.st == ssc_pkg::ST_REC && s_q.ssr ##1 s_q.st == ssc_pkg::ST_RUN);
  c_pin_cause: cover property ($rose(s_q.cause[`SSC_CAUSE_PIN]));
  c_wait_exit: cover property (
    s_q.st == ssc_pkg::ST_WAIT ##1 s_q.st == ssc_pkg::ST_RUN);
endmodule : ssc_top

/* rtl/ssc_params.svh */
// Register indices, field positions, reset values and timing counts
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH
`define SSC_IDX_FLAGS_LO 16'hfe04
`define SSC_IDX_FLAGS_MID 16'hfe05
`define SSC_IDX_FLAGS_HI 16'hfe06
`define SSC_IDX_CAUSE 16'hfe08
`define SSC_IDX_STATUS 16'hfe09
`define SSC_IDX_MASK 16'hfe0a
`define SSC_IDX_CTRL 16'hfe0b
`define SSC_CAUSE_POR 0
`define SSC_CAUSE_PIN 1
`define SSC_CAUSE_WDOG 2
`define SSC_CAUSE_ILOP 3
`define SSC_CAUSE_ILAD 4
`define SSC_CAUSE_USB 5
`define SSC_EV_STOP 0
`define SSC_EV_WAIT 1
`define SSC_EV_IRQ 2
`define SSC_CTRL_SSR 0
`define SSC_CTRL_RST 1'h0
`define SSC_MASK_RST 3'h0
`define SSC_POR_CYC 13'h1000
`define SSC_STOP_LONG 13'h1000
`define SSC_STOP_SHORT 13'h0020
`define SSC_DRIVE_CYC 6'h20
`define SSC_HOLD_CYC 6'h20
`define SSC_PIN_CYC 13'h0043
`define SSC_PIN_POR_CYC 13'h1043
`define SSC_VEC_USER 16'hfffe
`define SSC_VEC_MON 16'hfefe
`endif

/* rtl/ssc_pkg.sv */
// Types of the system state controller
package ssc_pkg;
  typedef enum logic [7:0] {
    ST_POR = 8'h01,
    ST_DRV = 8'h02,
    ST_HLD = 8'h04,
    ST_RUN = 8'h08,
    ST_EXT = 8'h10,
    ST_STOP = 8'h20,
    ST_REC = 8'h40,
    ST_WAIT = 8'h80
  } ssc_state_t;

  typedef struct packed {
    ssc_state_t st;
    logic [12:0] sys_cnt;
    logic [5:0] ph;
    logic [12:0] pin_cnt;
    logic por;
    logic [5:0] cause;
    logic [10:0] flags;
    logic pend;
    logic [2:0] sts;
    logic [2:0] msk;
    logic ssr;
    logic [7:0] rdata;
    logic wreq;
    logic internal_reset_signal;
    logic pin_oe;
    logic cpu_run;
    logic per_run;
    logic [15:0] vec;
    logic irq;
  } ssc_top_st_t;

  typedef struct packed {
    logic half;
    logic bus;
    logic cen;
    logic pen;
    logic cpu;
    logic per;
  } ssc_clk_st_t;
endpackage : ssc_pkg

/* rtl/ssc_bus_clk.sv */
// Bus clock divider and gating for CPU and peripheral clocks
`timescale 1ns/10ps
module ssc_bus_clk (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic cpu_run_in,
  input wire logic periph_run_in,
  output logic half_osc_clock_out,
  output logic cpu_clk_out,
  output logic periph_clk_out
);
  ssc_pkg::ssc_clk_st_t s_q;
  ssc_pkg::ssc_clk_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.half = ~s_q.half;
    if (s_q.half) begin
      s_d.bus = ~s_q.bus;
    end
    // Enables change only in the low phase, so no high pulse is cut short
    if (!s_d.bus) begin
      s_d.cen = cpu_run_in;
      s_d.pen = periph_run_in;
    end
    s_d.cpu = s_d.bus & s_d.cen;
    s_d.per = s_d.bus & s_d.pen;
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign half_osc_clock_out = s_q.half;
  assign cpu_clk_out = s_q.cpu;
  assign periph_clk_out = s_q.per;

  a_bus_quarter: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in)
    $rose(s_q.bus) |=> s_q.bus ##1 !s_q.bus ##1 !s_q.bus ##1 s_q.bus)
    else $error("bus clock is not a quarter of the oscillator");
endmodule : ssc_bus_clk

/* tb/ssc_pin_model.sv */
// Far-side model of the reset pin and its pull-up
`timescale 1ns/10ps
module ssc_pin_model (
  input wire logic oe_in,
  input wire logic drv_in,
  input wire logic pull_low_in,
  output logic level_out
);
  // Wired-and: either party pulls low, the pull-up wins when both let go
  assign level_out = (oe_in ? drv_in : 1'b1) & ~pull_low_in;
endmodule : ssc_pin_model

/* tb/tb.sv */
// Self-checking bench of the system state controller
`timescale 1ns/10ps
`include "ssc_params.svh"
module tb;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [17:0] addr = 18'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] rdata;
  logic wreq;
  logic pup = 1'b0;
  logic pin_lvl;
  logic pin_o;
  logic pin_oe;
  logic pull_low = 1'b0;
  logic [3:0] isrc = 4'h0;
  logic stop = 1'b0;
  logic wt = 1'b0;
  logic wake = 1'b0;
  logic mon = 1'b0;
  logic [23:0] src = 24'h0;
  logic internal_reset_signal;
  logic [15:0] vec;
  logic ipend;
  logic irq;
  logic half;
  logic cpu;
  logic per;
  int n_mismatch = 0;
  int compares = 0;

  always #25 mclk = ~mclk;

  // Full threshold: a shorter one lets our own power-on drive set the flag
  ssc_top i_dut (
    .mclk_in(mclk), .reset_n_in(reset_n), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .power_up_pulse_in(pup),
    .rst_pin_in(pin_lvl), .rst_pin_out(pin_o), .rst_pin_oe_out(pin_oe),
    .watchdog_timeout_in(isrc[0]), .illegal_opcode_in(isrc[1]),
    .illegal_addr_in(isrc[2]), .usb_reset_in(isrc[3]),
    .stop_req_in(stop), .wait_req_in(wt), .wake_in(wake),
    .monitor_mode_in(mon), .irq_src_in(src),
    .internal_reset_signal_out(internal_reset_signal), .reset_vector_out(vec),
    .irq_pending_out(ipend), .irq_out(irq), .half_osc_clock_out(half),
    .cpu_clk_out(cpu), .periph_clk_out(per)
  );

  ssc_pin_model i_pin (
    .oe_in(pin_oe), .drv_in(pin_o), .pull_low_in(pull_low),
    .level_out(pin_lvl)
  );

  task automatic end_of_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [15:0] idx,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge mclk);
    addr <= {idx, 2'b00};
    rd <= ~w;
    wr <= w;
    wdata <= {24'h0, d};
    be <= 4'hf;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic wreg(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask : wreg

  task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, idx, 8'h0, q);
    chk({24'h0, q}, {24'h0, exp});
  endtask : rdchk

  task automatic t_por;
    int n;
    int n_oe;
    int n_cpu;
    n = 0;
    n_oe = 0;
    n_cpu = 0;
    chk(pin_oe, 1);
    chk(pin_o, 0);
    chk(vec, 16'hfffe);
    @(posedge mclk);
    reset_n <= 1'b1;
    do begin
      @(posedge mclk);
      #1;
      n++;
      n_oe += (pin_oe === 1'b1);
      n_cpu += (cpu === 1'b1);
    end while (internal_reset_signal === 1'b1 && n < 9000);
    chk(n, 4160);
    // The cycle from release to the first edge drives too but is not sampled
    chk(n_oe + 1, 4128);
    chk(n_cpu, 0);
    rdchk(`SSC_IDX_CAUSE, 8'h01);
  endtask : t_por

  task automatic t_clk;
    logic ph;
    logic pc;
    int nh;
    int nc;
    nh = 0;
    nc = 0;
    @(posedge mclk);
    #1;
    ph = half;
    pc = cpu;
    repeat (16) begin
      @(posedge mclk);
      #1;
      nh += (half === 1'b1 && ph === 1'b0);
      nc += (cpu === 1'b1 && pc === 1'b0);
      ph = half;
      pc = cpu;
    end
    chk(nh, 8);
    chk(nc, 4);
  endtask : t_clk

  task automatic t_flags;
    logic [23:0] v;
    v = 24'hffa5a5;
    @(posedge mclk);
    src <= v;
    cyc(3);
    chk(ipend, 1);
    rdchk(`SSC_IDX_FLAGS_LO, {v[5:0], 2'b00});
    wreg(`SSC_IDX_FLAGS_LO, 8'hff);
    rdchk(`SSC_IDX_FLAGS_LO, {v[5:0], 2'b00});
    rdchk(`SSC_IDX_FLAGS_MID, {3'b000, v[10:6]});
    rdchk(`SSC_IDX_FLAGS_HI, 8'h00);
    rdchk(16'h0123, 8'h00);
    src <= 24'h0;
    cyc(2);
    rdchk(`SSC_IDX_FLAGS_LO, 8'h00);
    rdchk(`SSC_IDX_FLAGS_MID, 8'h00);
  endtask : t_flags

  task automatic t_int(input int k);
    int n_oe;
    int n_ir;
    n_oe = 0;
    n_ir = 0;
    wreg(`SSC_IDX_MASK, 8'h07);
    @(posedge mclk);
    mon <= (k == 1);
    isrc <= 4'h1 << k;
    @(posedge mclk);
    isrc <= 4'h0;
    #1;
    repeat (100) begin
      n_oe += (pin_oe === 1'b1);
      n_ir += (internal_reset_signal === 1'b1);
      @(posedge mclk);
      #1;
    end
    chk(n_oe, 32);
    chk(n_ir, 64);
    chk(vec, (k == 1) ? 16'hfefe : 16'hfffe);
    mon <= 1'b0;
    rdchk(`SSC_IDX_CAUSE, 8'h04 << k);
    rdchk(`SSC_IDX_MASK, 8'h00);
  endtask : t_int

  task automatic t_pin;
    int n;
    n = 0;
    @(posedge mclk);
    pull_low <= 1'b1;
    cyc(35);
    chk(internal_reset_signal, 1);
    chk(cpu, 0);
    cyc(35);
    pull_low <= 1'b0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (internal_reset_signal === 1'b1 && n < 200);
    // Pin reset keeps the bus reset cause left by the last internal reset
    rdchk(`SSC_IDX_CAUSE, 8'h22);
  endtask : t_pin

  // Lower bound proves clocks stay off; upper bound allows divider phase
  task automatic t_stop(input logic s, input int lo, input int hi);
    int n;
    n = 0;
    wreg(`SSC_IDX_CTRL, {7'h0, s});
    wreg(`SSC_IDX_STATUS, 8'h07);
    wreg(`SSC_IDX_MASK, 8'h01);
    @(posedge mclk);
    stop <= 1'b1;
    @(posedge mclk);
    stop <= 1'b0;
    cyc(8);
    wake <= 1'b1;
    @(posedge mclk);
    wake <= 1'b0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (cpu !== 1'b1 && n < 5000);
    chk(n >= lo && n <= hi, 1);
    rdchk(`SSC_IDX_STATUS, 8'h01);
    chk(irq, 1);
    wreg(`SSC_IDX_STATUS, 8'h01);
    cyc(2);
    chk(irq, 0);
  endtask : t_stop

  task automatic t_wait;
    logic pc;
    logic pp;
    int nc;
    int np;
    nc = 0;
    np = 0;
    @(posedge mclk);
    wt <= 1'b1;
    @(posedge mclk);
    wt <= 1'b0;
    cyc(6);
    #1;
    pc = cpu;
    pp = per;
    repeat (16) begin
      @(posedge mclk);
      #1;
      nc += (cpu !== pc);
      np += (per === 1'b1 && pp === 1'b0);
      pc = cpu;
      pp = per;
    end
    chk(nc, 0);
    chk(np, 4);
    @(posedge mclk);
    wake <= 1'b1;
    @(posedge mclk);
    wake <= 1'b0;
    cyc(4);
    rdchk(`SSC_IDX_STATUS, 8'h02);
  endtask : t_wait

  initial begin
    #1500000;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge mclk);
    t_por();
    t_clk();
    t_flags();
    for (int k = 0; k < 4; k++) begin
      t_int(k);
    end
    t_pin();
    t_stop(1'b1, 30, 40);
    t_stop(1'b0, 4094, 4104);
    t_wait();
    end_of_test();
  end
endmodule : tb
